// ===== pcc_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_checker #(
    parameter int MEM_BYTES = 4096,
    parameter int TIMEOUT_CYC = pcc_pkg::PAR_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_control_enable,
    input wire logic rec_valid,
    input wire pcc_pkg::pcc_rec_t rec,
    input wire pcc_pkg::pcc_range_t range_fault,
    input wire logic gear_below_one,
    input wire logic signed [31:0] scaled_pos,
    input wire logic par_start,
    input wire logic par_done,
    output logic done,
    output logic accepted,
    output logic [7:0] error_code,
    output logic error_valid,
    output logic job_prepared,
    output logic exec_data_seen,
    output logic [15:0] occupied,
    output logic [15:0] mem_free,
    output logic par_busy
);
    typedef struct packed {
        logic [1:0] hce_sync;
        logic done;
        logic accepted;
        logic [7:0] error_code;
        logic error_valid;
        logic job_prepared;
        logic exec_data_seen;
        logic [15:0] occupied;
        logic [15:0] mem_used;
        logic [15:0] mem_free;
        logic par_busy;
    } pcc_state_t;

    pcc_state_t st;
    pcc_state_t next_st;
    pcc_pkg::pcc_verdict_t v;
    logic par_expired;
    logic hce;
    logic [15:0] prog_bit;
    logic [16:0] used_after;
    logic [6:0] need_len;

    // ==================== transfer watchdog ====================
    pcc_par_timer #(
        .TIMEOUT_CYC(TIMEOUT_CYC)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .busy(st.par_busy),
        .expired(par_expired)
    );

    // enable pin is asynchronous; only the second stage is read
    assign hce = st.hce_sync[1];
    assign prog_bit = 16'h1 << rec.prog_num;
    assign used_after = {1'b0, st.mem_used} + {1'b0, rec.prog_size};

    always_comb begin
        unique case (pcc_pkg::pcc_cmd_t'(rec.code))
            pcc_pkg::PCC_CMD_START: need_len = pcc_pkg::LEN_START;
            pcc_pkg::PCC_CMD_ERASE: need_len = pcc_pkg::LEN_ERASE;
            pcc_pkg::PCC_CMD_EXEC_REPEAT:
                need_len = pcc_pkg::LEN_EXEC_REPEAT;
            pcc_pkg::PCC_CMD_SEL_PROG: need_len = pcc_pkg::LEN_SEL_PROG;
            default: need_len = 7'h00;
        endcase
    end

    // ==================== verdict ====================
    // checks run in fixed priority so exactly one code is reported:
    // host enable first, then framing, then content, then program store and job sequencing
    always_comb begin
        v = '0;
        if (!hce) begin
            v.code = pcc_pkg::ERR_NO_HOST_CTRL;
        end else if (rec.byte_count > 7'(pcc_pkg::MAX_BLOCK_BYTES)) begin
            v.code = pcc_pkg::ERR_BLOCK_LONG;
        end else if (rec.serial_mode && rec.code > pcc_pkg::CMD_LAST) begin
            v.code = pcc_pkg::ERR_BAD_CODE;
        end else if (rec.serial_mode && need_len != 7'h00
                     && rec.byte_count != need_len) begin
            v.code = pcc_pkg::ERR_BAD_FORMAT;
        end else if (rec.action_count > 3'h1) begin
            v.code = pcc_pkg::ERR_MULTI_ACTION;
        end else if (rec.repeated_setting || (rec.abs_sel && rec.rel_sel))
        begin
            v.code = pcc_pkg::ERR_REPEAT_SET;
        end else if (range_fault.par_readings) begin
            v.code = pcc_pkg::ERR_PAR_READINGS;
        end else if (range_fault.dec_settle) begin
            v.code = pcc_pkg::ERR_DEC_SETTLE;
        end else if (range_fault.ref_pos) begin
            v.code = pcc_pkg::ERR_REF_POS;
        end else if (range_fault.move_freq) begin
            v.code = pcc_pkg::ERR_MOVE_FREQ;
        end else if (range_fault.ramp) begin
            v.code = pcc_pkg::ERR_RAMP;
        end else if (range_fault.sec_rate) begin
            v.code = pcc_pkg::ERR_SEC_RATE;
        end else if (gear_below_one && (scaled_pos > pcc_pkg::POS_LIMIT
                     || scaled_pos < -pcc_pkg::POS_LIMIT)) begin
            v.code = pcc_pkg::ERR_POS_OVF;
        end else begin
            unique case (pcc_pkg::pcc_cmd_t'(rec.code))
                pcc_pkg::PCC_CMD_LOAD_PROG: begin
                    if (rec.prog_count > 5'(pcc_pkg::MAX_PROGS)) begin
                        v.code = pcc_pkg::ERR_TOO_MANY_PROGS;
                    end else if (rec.prog_count == 5'h00) begin
                        v.code = pcc_pkg::ERR_STORE_COUNT;
                    end else if ((st.occupied & prog_bit) != 16'h0) begin
                        v.code = pcc_pkg::ERR_PROG_OCCUPIED;
                    end else if (used_after > 17'(MEM_BYTES)) begin
                        v.code = pcc_pkg::ERR_MEM_FULL;
                    end else if (rec.prog_len_received
                                 != rec.prog_len_declared) begin
                        v.code = pcc_pkg::ERR_BYTE_COUNT;
                    end else if (rec.checksum_computed
                                 != rec.checksum_declared) begin
                        v.code = pcc_pkg::ERR_CHECKSUM;
                    end
                end
                pcc_pkg::PCC_CMD_DEL_PROG, pcc_pkg::PCC_CMD_SEL_PROG: begin
                    if ((st.occupied & prog_bit) == 16'h0) begin
                        v.code = pcc_pkg::ERR_PROG_EMPTY;
                    end
                end
                pcc_pkg::PCC_CMD_ERASE: begin
                    if (!st.job_prepared) begin
                        v.code = pcc_pkg::ERR_ERASE_NONE;
                    end
                end
                pcc_pkg::PCC_CMD_START: begin
                    if (!st.job_prepared) begin
                        v.code = pcc_pkg::ERR_START_NONE;
                    end
                end
                pcc_pkg::PCC_CMD_EXEC: begin
                    if (st.job_prepared) begin
                        v.code = pcc_pkg::ERR_EXEC_PENDING;
                    end
                end
                pcc_pkg::PCC_CMD_EXEC_REPEAT: begin
                    if (st.job_prepared) begin
                        v.code = pcc_pkg::ERR_EXEC_PENDING;
                    end else if (!st.exec_data_seen) begin
                        v.code = pcc_pkg::ERR_REPEAT_NONE;
                    end
                end
                default: v.code = pcc_pkg::ERR_NONE;
            endcase
        end
        v.reject = (v.code != pcc_pkg::ERR_NONE);
        v.accept = !v.reject;
    end

    // ==================== state update ====================
    always_comb begin
        next_st = st;
        next_st.hce_sync = {st.hce_sync[0], host_control_enable};
        next_st.done = 1'b0;
        next_st.accepted = 1'b0;
        if (par_start && !st.par_busy) begin
            next_st.par_busy = 1'b1;
        end else if (par_done) begin
            next_st.par_busy = 1'b0;
        end
        if (par_expired && st.par_busy) begin
            next_st.par_busy = 1'b0;
            next_st.error_code = pcc_pkg::ERR_PAR_TIMEOUT;
            next_st.error_valid = 1'b1;
            next_st.done = 1'b1;
        end else if (rec_valid) begin
            next_st.done = 1'b1;
            next_st.accepted = v.accept;
            if (v.reject) begin
                // a rejected record touches nothing but the error latch
                next_st.error_code = v.code;
                next_st.error_valid = 1'b1;
            end else begin
                next_st.error_code = pcc_pkg::ERR_NONE;
                next_st.error_valid = 1'b0;
                unique case (pcc_pkg::pcc_cmd_t'(rec.code))
                    pcc_pkg::PCC_CMD_LOAD_PROG: begin
                        next_st.occupied = st.occupied | prog_bit;
                        next_st.mem_used = used_after[15:0];
                    end
                    pcc_pkg::PCC_CMD_DEL_PROG: begin
                        next_st.occupied = st.occupied & ~prog_bit;
                    end
                    pcc_pkg::PCC_CMD_PREPARE: next_st.job_prepared = 1'b1;
                    pcc_pkg::PCC_CMD_START: next_st.job_prepared = 1'b0;
                    pcc_pkg::PCC_CMD_ERASE: next_st.job_prepared = 1'b0;
                    pcc_pkg::PCC_CMD_EXEC: next_st.exec_data_seen = 1'b1;
                    default: next_st.job_prepared = st.job_prepared;
                endcase
            end
        end
        // free space kept in a register so the output leaves a flip-flop
        next_st.mem_free = 16'(MEM_BYTES) - next_st.mem_used;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '{mem_free: 16'(MEM_BYTES), default: '0};
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;
    assign accepted = st.accepted;
    assign error_code = st.error_code;
    assign error_valid = st.error_valid;
    assign job_prepared = st.job_prepared;
    assign exec_data_seen = st.exec_data_seen;
    assign occupied = st.occupied;
    // memory usage limited by the MEM_BYTES parameter; deletion does not
    // reclaim space because the record holds no size of the deleted program
    assign mem_free = st.mem_free;
    assign par_busy = st.par_busy;
endmodule : pcc_checker
`default_nettype wire

// ===== pcc_checker_test.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_checker_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic host_control_enable, rec_valid, gear_below_one, par_start, par_done;
    pcc_pkg::pcc_rec_t rec;
    pcc_pkg::pcc_range_t range_fault;
    logic signed [31:0] scaled_pos;
    logic done, accepted, error_valid, job_prepared, exec_data_seen, par_busy;
    logic [7:0] error_code;
    logic [15:0] occupied, mem_free;
    int miscompares = 0;
    int compares = 0;
    always #25 clk_sys = ~clk_sys;

    pcc_host_model u_host (.clk_sys(clk_sys),
        .host_control_enable(host_control_enable), .rec_valid(rec_valid),
        .rec(rec), .range_fault(range_fault), .gear_below_one(gear_below_one),
        .scaled_pos(scaled_pos), .par_start(par_start), .par_done(par_done));
    // short timeout and tiny memory keep the run brief
    pcc_checker #(.MEM_BYTES(64), .TIMEOUT_CYC(50)) dut (.clk_sys(clk_sys),
        .rst(rst), .host_control_enable(host_control_enable),
        .rec_valid(rec_valid), .rec(rec), .range_fault(range_fault),
        .gear_below_one(gear_below_one), .scaled_pos(scaled_pos),
        .par_start(par_start), .par_done(par_done), .done(done),
        .accepted(accepted), .error_code(error_code),
        .error_valid(error_valid), .job_prepared(job_prepared),
        .exec_data_seen(exec_data_seen), .occupied(occupied),
        .mem_free(mem_free), .par_busy(par_busy));

    // ==================== helpers ====================
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task wrap_up;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    function automatic pcc_pkg::pcc_rec_t mk(input logic [3:0] c,
                                             input logic [6:0] n);
        pcc_pkg::pcc_rec_t r;
        r = '0;
        {r.code, r.byte_count, r.prog_count, r.action_count} = {c, n, 8'h21};
        r.prog_len_declared = 16'h0008;
        r.prog_len_received = 16'h0008;
        r.checksum_declared = 8'h5A;
        r.checksum_computed = 8'h5A;
        r.prog_size = 16'h0010;
        r.serial_mode = 1'b1;
        return r;
    endfunction : mk
    task run(input pcc_pkg::pcc_rec_t r, input logic [5:0] f, input logic g,
             input logic signed [31:0] p, input logic [7:0] e);
        u_host.send(r, pcc_pkg::pcc_range_t'(f), g, p);
        chk({5'h00, done, accepted, error_valid, error_code},
            {5'h00, 1'b1, e == 8'h00, e != 8'h00, e});
    endtask : run
    task rs(input pcc_pkg::pcc_rec_t r, input logic [7:0] e);
        run(r, 6'h00, 1'b0, 32'sh0, e);
    endtask : rs

    // ==================== scenarios ====================
    task t_host;
        rs(mk(pcc_pkg::PCC_CMD_START, 7'h02), 8'h93);
        u_host.enable(1'b1);
        u_host.enable(1'b0);
        rs(mk(pcc_pkg::PCC_CMD_START, 7'h02), 8'h93);
        u_host.enable(1'b1);
        $display("host enable test ended");
    endtask : t_host
    task t_job;
        rs(mk(pcc_pkg::PCC_CMD_START, 7'h02), 8'hCB);
        rs(mk(pcc_pkg::PCC_CMD_ERASE, 7'h02), 8'hC4);
        rs(mk(pcc_pkg::PCC_CMD_EXEC_REPEAT, 7'h02), 8'hCC);
        chk({15'h0000, exec_data_seen}, 16'h0000);
        rs(mk(pcc_pkg::PCC_CMD_PREPARE, 7'h08), 8'h00);
        rs(mk(pcc_pkg::PCC_CMD_EXEC, 7'h08), 8'hCA);
        chk({15'h0000, job_prepared}, 16'h0001);
        rs(mk(pcc_pkg::PCC_CMD_ERASE, 7'h02), 8'h00);
        rs(mk(pcc_pkg::PCC_CMD_PREPARE, 7'h08), 8'h00);
        rs(mk(pcc_pkg::PCC_CMD_START, 7'h02), 8'h00);
        rs(mk(pcc_pkg::PCC_CMD_EXEC, 7'h08), 8'h00);
        chk({15'h0000, exec_data_seen}, 16'h0001);
        rs(mk(pcc_pkg::PCC_CMD_EXEC_REPEAT, 7'h02), 8'h00);
        $display("job sequencing test ended");
    endtask : t_job
    task t_fmt;
        pcc_pkg::pcc_rec_t x;
        logic [7:0] codes [6];
        codes = '{8'hAA, 8'hAB, 8'hAC, 8'hC7, 8'hC8, 8'hC9};
        x = mk(pcc_pkg::PCC_CMD_PARAM, 7'h0A);
        rs(mk(4'hA, 7'h0A), 8'hC1);
        rs(mk(pcc_pkg::PCC_CMD_START, 7'h03), 8'hC2);
        // outside serial mode an unknown code is not refused
        {x.code, x.serial_mode} = {4'hA, 1'b0};
        rs(x, 8'h00);
        {x.code, x.serial_mode} = {pcc_pkg::PCC_CMD_PARAM, 1'b1};
        x.action_count = 3'h2;
        rs(x, 8'hC5);
        x.action_count = 3'h1;
        x.repeated_setting = 1'b1;
        rs(x, 8'hC6);
        {x.repeated_setting, x.abs_sel, x.rel_sel} = 3'h3;
        rs(x, 8'hC6);
        {x.abs_sel, x.rel_sel} = 2'h0;
        for (int i = 0; i < 6; i++) begin
            run(x, 6'(6'h20 >> i), 1'b0, 32'sh0, codes[i]);
        end
        run(x, 6'h00, 1'b1, 32'sh00800000, 8'hAF);
        run(x, 6'h00, 1'b1, -32'sh00800000, 8'hAF);
        run(x, 6'h00, 1'b1, 32'sh007FFFFF, 8'h00);
        run(x, 6'h00, 1'b1, -32'sh007FFFFF, 8'h00);
        run(x, 6'h00, 1'b0, 32'sh00800000, 8'h00);
        $display("format and range test ended");
    endtask : t_fmt
    task t_prog;
        pcc_pkg::pcc_rec_t x;
        x = mk(pcc_pkg::PCC_CMD_LOAD_PROG, 7'h40);
        rs(x, 8'h00);
        chk(mem_free, 16'h0030);
        x.byte_count = 7'h41;
        rs(x, 8'hC0);
        x.byte_count = 7'h14;
        rs(x, 8'hB0);
        {x.prog_num, x.prog_count} = {4'h1, 5'h11};
        rs(x, 8'hB3);
        x.prog_count = 5'h00;
        rs(x, 8'hB6);
        x.prog_count = 5'h10;
        rs(x, 8'h00);
        {x.prog_num, x.prog_count, x.prog_size} = {4'h2, 5'h01, 16'h0028};
        rs(x, 8'hB1);
        {x.prog_size, x.prog_len_received} = {16'h0008, 16'h0007};
        rs(x, 8'hB4);
        x.prog_len_received = 16'h0008;
        x.checksum_computed = 8'h5B;
        rs(x, 8'hB2);
        chk(occupied, 16'h0003);
        chk(mem_free, 16'h0020);
        x = mk(pcc_pkg::PCC_CMD_SEL_PROG, 7'h03);
        x.prog_num = 4'h5;
        rs(x, 8'hB8);
        x.code = pcc_pkg::PCC_CMD_DEL_PROG;
        rs(x, 8'hB8);
        {x.code, x.prog_num} = {pcc_pkg::PCC_CMD_SEL_PROG, 4'h1};
        rs(x, 8'h00);
        x.byte_count = 7'h04;
        rs(x, 8'hC2);
        $display("program store test ended");
    endtask : t_prog
    task t_par;
        u_host.par(5, 1'b1);
        chk({15'h0000, par_busy}, 16'h0000);
        u_host.par(0, 1'b0);
        for (int k = 0; k < 200 && done !== 1'b1; k++) @(negedge clk_sys);
        chk({6'h00, par_busy, done, error_code}, 16'h01B5);
        $display("parallel timeout test ended");
    endtask : t_par

    // ==================== main ====================
    initial begin
        repeat (8) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        t_host;
        t_job;
        t_fmt;
        t_prog;
        t_par;
        wrap_up;
    end
    // about 200 cycles are needed; this leaves wide margin
    initial begin
        repeat (3000) @(negedge clk_sys);
        miscompares++;
        $display("BAD %0t watchdog expired", $time);
        wrap_up;
    end
endmodule : pcc_checker_test
`default_nettype wire

// ===== pcc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
    input wire logic clk_sys,
    output logic host_control_enable,
    output logic rec_valid,
    output var pcc_pkg::pcc_rec_t rec,
    output var pcc_pkg::pcc_range_t range_fault,
    output logic gear_below_one,
    output logic signed [31:0] scaled_pos,
    output logic par_start,
    output logic par_done
);
    // ==================== host side ====================
    initial begin
        {host_control_enable, rec_valid, gear_below_one} = 3'h0;
        {par_start, par_done} = 2'h0;
        rec = '0;
        range_fault = '0;
        scaled_pos = '0;
    end
    // one action per record unless the bench asks for a refusal
    task send(input pcc_pkg::pcc_rec_t r, input pcc_pkg::pcc_range_t f,
              input logic g, input logic signed [31:0] p);
        @(negedge clk_sys);
        {rec, range_fault, gear_below_one, scaled_pos} = {r, f, g, p};
        rec_valid = 1'b1;
        @(negedge clk_sys);
        rec_valid = 1'b0;
        // stale data is inverted so nothing relies on it lingering
        {rec, range_fault, gear_below_one, scaled_pos} = ~{r, f, g, p};
    endtask : send
    task enable(input logic e);
        @(negedge clk_sys);
        host_control_enable = e;
        repeat (3) @(negedge clk_sys);
    endtask : enable
    task par(input int n, input logic fin);
        @(negedge clk_sys);
        par_start = 1'b1;
        @(negedge clk_sys);
        par_start = 1'b0;
        repeat (n) @(negedge clk_sys);
        if (fin) begin
            par_done = 1'b1;
            @(negedge clk_sys);
            par_done = 1'b0;
        end
    endtask : par
endmodule : pcc_host_model
`default_nettype wire

// ===== pcc_par_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_par_timer #(
    parameter int TIMEOUT_CYC = pcc_pkg::PAR_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic busy,
    output logic expired
);
    typedef struct packed {
        logic [31:0] count;
        logic expired;
    } pcc_tmr_t;
    pcc_tmr_t st;
    pcc_tmr_t next_st;

    // ==================== timeout counter ====================
    always_comb begin
        next_st = st;
        next_st.expired = 1'b0;
        if (!busy) begin
            next_st.count = 32'h0;
        end else if (st.count == 32'(TIMEOUT_CYC - 1)) begin
            next_st.expired = 1'b1;
            next_st.count = 32'h0;
        end else begin
            next_st.count = st.count + 32'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign expired = st.expired;
endmodule : pcc_par_timer
`default_nettype wire

// ===== pcc_pkg.sv
`default_nettype none
package pcc_pkg;
    // ==================== error codes ====================
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_NO_HOST_CTRL = 8'h93;
    localparam logic [7:0] ERR_PAR_READINGS = 8'hAA;
    localparam logic [7:0] ERR_DEC_SETTLE = 8'hAB;
    localparam logic [7:0] ERR_REF_POS = 8'hAC;
    localparam logic [7:0] ERR_POS_OVF = 8'hAF;
    localparam logic [7:0] ERR_PROG_OCCUPIED = 8'hB0;
    localparam logic [7:0] ERR_MEM_FULL = 8'hB1;
    localparam logic [7:0] ERR_CHECKSUM = 8'hB2;
    localparam logic [7:0] ERR_TOO_MANY_PROGS = 8'hB3;
    localparam logic [7:0] ERR_BYTE_COUNT = 8'hB4;
    localparam logic [7:0] ERR_PAR_TIMEOUT = 8'hB5;
    localparam logic [7:0] ERR_STORE_COUNT = 8'hB6;
    localparam logic [7:0] ERR_PROG_EMPTY = 8'hB8;
    localparam logic [7:0] ERR_BLOCK_LONG = 8'hC0;
    localparam logic [7:0] ERR_BAD_CODE = 8'hC1;
    localparam logic [7:0] ERR_BAD_FORMAT = 8'hC2;
    localparam logic [7:0] ERR_ERASE_NONE = 8'hC4;
    localparam logic [7:0] ERR_MULTI_ACTION = 8'hC5;
    localparam logic [7:0] ERR_REPEAT_SET = 8'hC6;
    localparam logic [7:0] ERR_MOVE_FREQ = 8'hC7;
    localparam logic [7:0] ERR_RAMP = 8'hC8;
    localparam logic [7:0] ERR_SEC_RATE = 8'hC9;
    localparam logic [7:0] ERR_EXEC_PENDING = 8'hCA;
    localparam logic [7:0] ERR_START_NONE = 8'hCB;
    localparam logic [7:0] ERR_REPEAT_NONE = 8'hCC;

    // ==================== limits ====================
    localparam int MAX_BLOCK_BYTES = 64;
    localparam int MAX_PROGS = 16;
    localparam logic signed [31:0] POS_LIMIT = 32'sd8388607;
    localparam int CLK_HZ = 20000000;
    localparam int PAR_TIMEOUT_S = 5;
    localparam int PAR_TIMEOUT_CYC = PAR_TIMEOUT_S * CLK_HZ;

    // ==================== command codes ====================
    typedef enum logic [3:0] {
        PCC_CMD_LOAD_PROG = 4'h0,
        PCC_CMD_DEL_PROG = 4'h1,
        PCC_CMD_SEL_PROG = 4'h2,
        PCC_CMD_PARAM = 4'h3,
        PCC_CMD_PREPARE = 4'h4,
        PCC_CMD_START = 4'h5,
        PCC_CMD_ERASE = 4'h6,
        PCC_CMD_EXEC = 4'h7,
        PCC_CMD_EXEC_REPEAT = 4'h8,
        PCC_CMD_MOTION = 4'h9
    } pcc_cmd_t;
    localparam logic [3:0] CMD_LAST = 4'h9;

    // fixed record lengths; zero means variable length
    localparam logic [6:0] LEN_START = 7'h02;
    localparam logic [6:0] LEN_ERASE = 7'h02;
    localparam logic [6:0] LEN_EXEC_REPEAT = 7'h02;
    localparam logic [6:0] LEN_SEL_PROG = 7'h03;

    // ==================== record summary ====================
    typedef struct packed {
        logic [3:0] code;
        logic [6:0] byte_count;
        logic [4:0] prog_count;
        logic [3:0] prog_num;
        logic [15:0] prog_len_declared;
        logic [15:0] prog_len_received;
        logic [7:0] checksum_declared;
        logic [7:0] checksum_computed;
        logic [15:0] prog_size;
        logic [2:0] action_count;
        logic repeated_setting;
        logic abs_sel;
        logic rel_sel;
        logic serial_mode;
    } pcc_rec_t;

    // one range fault flag per checked parameter value
    typedef struct packed {
        logic par_readings;
        logic dec_settle;
        logic ref_pos;
        logic move_freq;
        logic ramp;
        logic sec_rate;
    } pcc_range_t;

    typedef struct packed {
        logic accept;
        logic reject;
        logic [7:0] code;
    } pcc_verdict_t;
endpackage : pcc_pkg
`default_nettype wire

// ===== pcc_rules_checker.sv
`timescale 1ns/1ps
`default_nettype none
module pcc_rules_checker #(
    parameter int TIMEOUT_CYC = pcc_pkg::PAR_TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic host_control_enable,
    input wire logic rec_valid,
    input wire pcc_pkg::pcc_rec_t rec,
    input wire logic par_done,
    input wire logic done,
    input wire logic accepted,
    input wire logic [7:0] error_code,
    input wire logic error_valid,
    input wire logic job_prepared,
    input wire logic [15:0] occupied,
    input wire logic par_busy
);
    // ==================== helper state ====================
    // enable is trusted only after three high samples: the design
    // synchroniser lags two cycles and we must not race it
    logic [1:0] en_cnt;
    logic ever_hi;
    int busy_cnt;
    logic ok;
    always_ff @(posedge clk_sys) begin
        if (rst || !host_control_enable) en_cnt <= 2'h0;
        else if (en_cnt != 2'h3) en_cnt <= en_cnt + 2'h1;
        ever_hi <= rst ? 1'b0 : (ever_hi | host_control_enable);
        busy_cnt <= (rst || !par_busy) ? 0 : busy_cnt + 1;
    end
    assign ok = en_cnt == 2'h3 && !par_busy;

    // ==================== properties ====================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_answer; rec_valid |=> done; endproperty
    property p_accept;
        accepted |-> done && error_code == 8'h00 && !error_valid;
    endproperty
    property p_reject;
        done && !accepted |-> error_valid && error_code != 8'h00;
    endproperty
    property p_hold; !done |-> $stable(error_code); endproperty
    property p_keep;
        done && !accepted |-> $stable(job_prepared) && $stable(occupied);
    endproperty
    property p_no_host;
        rec_valid && !ever_hi |=> error_code == 8'h93;
    endproperty
    property p_long;
        rec_valid && ok && rec.byte_count > 7'h40 |=> error_code == 8'hC0;
    endproperty
    property p_bad_code;
        rec_valid && ok && rec.byte_count <= 7'h40 && rec.serial_mode
            && rec.code > pcc_pkg::CMD_LAST |=> error_code == 8'hC1;
    endproperty
    property p_to_fell;
        $fell(par_busy) && !$past(par_done) |-> done && error_code == 8'hB5;
    endproperty
    property p_to_len; par_busy |-> busy_cnt <= TIMEOUT_CYC; endproperty

    a_answer: assert property (p_answer)
        else $error("no verdict after record");
    a_accept: assert property (p_accept)
        else $error("accept with error code");
    a_reject: assert property (p_reject)
        else $error("reject without error code");
    a_hold: assert property (p_hold)
        else $error("error code moved without verdict");
    a_keep: assert property (p_keep)
        else $error("rejected record changed state");
    a_no_host: assert property (p_no_host)
        else $error("command without host enable not refused");
    a_long: assert property (p_long)
        else $error("long block not refused");
    a_bad_code: assert property (p_bad_code)
        else $error("undefined command not refused");
    a_to_fell: assert property (p_to_fell)
        else $error("transfer ended without handshake or timeout");
    a_to_len: assert property (p_to_len)
        else $error("parallel transfer ran past timeout");

    c_accept: cover property (accepted);
    c_timeout: cover property (done && error_code == 8'hB5);
    c_long: cover property (done && error_code == 8'hC0);
endmodule : pcc_rules_checker

bind pcc_checker pcc_rules_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_rules (
    .clk_sys(clk_sys), .rst(rst), .host_control_enable(host_control_enable),
    .rec_valid(rec_valid), .rec(rec), .par_done(par_done), .done(done),
    .accepted(accepted), .error_code(error_code), .error_valid(error_valid),
    .job_prepared(job_prepared), .occupied(occupied), .par_busy(par_busy));
`default_nettype wire
